// ==== hdl/addr_map_decode.sv ====
// System address map decoder: routes processor and inbound requests,
// widens them to the internal address, and picks the outbound format.
// Assumes requesters on the same clock; one request per port per cycle.
`timescale 1ns/1ns

// Behaviour
// - Outbound address under 4 GB uses 32-bit format
// - 64-bit format only above 32 significant bits
// - 64-bit format taken inbound, produced outbound
// - Internal address and limit are 40 bits
// - Processors give 36-bit memory, 16-bit I/O
// - Memory channels see 36-bit local address
// - Legacy sections individually off, RW, WO, RO
// - Fixed compat, interrupt and system ranges decoded
module addr_map_decode
	import addr_map_pkg::*;
#(
	parameter logic [INT_AW-1:0] INTR_BASE = INTR_BASE_DEF,
	parameter logic [INT_AW-1:0] INTR_SIZE = INTR_SIZE_DEF,
	parameter int                NSECT     = N_SECT
) (
	input  wire logic                 mclk_i,       // 20 MHz clock
	input  wire logic                 reset_n_i,    // Sync reset, low
	// Processor request
	input  wire logic                 cpu_valid_i,  // Request strobe
	input  wire logic                 cpu_io_i,     // 1: I/O space
	input  wire logic                 cpu_write_i,  // 1: write
	input  wire logic [CPU_AW-1:0]    cpu_addr_i,   // Memory address
	input  wire logic [IO_AW-1:0]     cpu_ioaddr_i, // I/O address
	// Configuration levels
	input  wire logic [2*NSECT-1:0]   sect_attr_i,  // Legacy attributes
	input  wire logic [INT_AW-1:0]    dram_top_i,   // End of DRAM
	// Inbound request from a PCI Express port
	input  wire logic                 ib_valid_i,   // Request strobe
	input  wire logic                 ib_fmt64_i,   // 64-bit header
	input  wire logic                 ib_write_i,   // 1: write
	input  wire logic [PCIE_AW-1:0]   ib_addr_i,    // Header address
	// Processor result
	output logic                      cpu_done_o,   // Result pulse
	output target_type                cpu_tgt_o,    // Route
	output logic [INT_AW-1:0]         int_addr_o,   // Internal address
	output logic [CHAN_AW-1:0]        chan_addr_o,  // Channel address
	output logic [IO_AW-1:0]          io_addr_o,    // I/O address
	// Outbound PCI Express header address
	output logic                      ob_valid_o,   // Outbound pulse
	output logic                      ob_write_o,   // 1: write
	output logic                      ob_fmt64_o,   // 1: 64-bit form
	output logic [SHORT_AW-1:0]       ob_addr_hi_o, // Upper dword
	output logic [SHORT_AW-1:0]       ob_addr_lo_o, // Lower dword
	// Inbound result
	output logic                      ib_done_o,    // Result pulse
	output target_type                ib_tgt_o,     // Route
	output logic                      ib_write_o,   // 1: write
	output logic [INT_AW-1:0]         ib_int_o,     // Internal address
	output logic [CHAN_AW-1:0]        ib_chan_o,    // Channel address
	output logic                      ib_range_err_o // Beyond 40 bits
);

	// ****************************************************************
	// Functions
	// ****************************************************************

	// Legacy section index for an address below 1 MB in 0xc0000..
	function automatic logic [SECT_IW-1:0] sect_index(
		input logic [INT_AW-1:0] a
	);
		logic [5:0] s;
		s = a[SECT_SHIFT+5:SECT_SHIFT] - SECT_FIRST;
		if (a >= SEG_F_BASE)
			sect_index = SECT_IW'(NSECT - 1);
		else
			sect_index = s[SECT_IW-1:0];
	endfunction : sect_index

	// Shared memory-space decode for processor and inbound requests
	function automatic target_type decode_mem(
		input logic [INT_AW-1:0]  a,
		input logic               wr,
		input logic [2*NSECT-1:0] attr,
		input logic [INT_AW-1:0]  top
	);
		logic [SECT_IW-1:0] idx;
		logic [1:0]         at;
		idx = sect_index(a);
		at  = attr[2*idx +: 2];
		// Fixed ranges first, relocatable DRAM after
		// Overlap is not checked; first match wins
		if (a < DOS_TOP)
			decode_mem = TGT_DRAM;
		else if (a < VGA_TOP)
			decode_mem = TGT_COMPAT;
		else if (a < COMPAT_TOP) begin
			// Off sends both directions to the compat port
			if (wr ? at[ATTR_WR_BIT] : at[ATTR_RD_BIT])
				decode_mem = TGT_DRAM;
			else
				decode_mem = TGT_COMPAT;
		end else if (a >= INTR_BASE && a < INTR_BASE + INTR_SIZE)
			decode_mem = TGT_INTR;
		else if (a >= SYS_BASE && a < FOUR_GB)
			decode_mem = TGT_SYSREG;
		else if (a < top)
			decode_mem = TGT_DRAM;
		else
			decode_mem = TGT_PCIE;
	endfunction : decode_mem

	// ****************************************************************
	// Processor path
	// ****************************************************************
	logic                cpu_done_r,   cpu_done_nxt;
	target_type          cpu_tgt_r,    cpu_tgt_nxt;
	logic [INT_AW-1:0]   int_addr_r,   int_addr_nxt;
	logic [CHAN_AW-1:0]  chan_addr_r,  chan_addr_nxt;
	logic [IO_AW-1:0]    io_addr_r,    io_addr_nxt;
	logic                ob_valid_r,   ob_valid_nxt;
	logic                ob_write_r,   ob_write_nxt;
	logic                ob_fmt64_r,   ob_fmt64_nxt;
	logic [SHORT_AW-1:0] ob_hi_r,      ob_hi_nxt;
	logic [SHORT_AW-1:0] ob_lo_r,      ob_lo_nxt;

	always_comb begin
		logic [INT_AW-1:0]  wide;
		logic [PCIE_AW-1:0] ob_full;
		target_type         t;
		// Processor memory address is zero-extended to 40 bits
		wide    = {{(INT_AW-CPU_AW){1'b0}}, cpu_addr_i};
		ob_full = {{(PCIE_AW-INT_AW){1'b0}}, wide};
		t       = decode_mem(wide, cpu_write_i, sect_attr_i, dram_top_i);
		cpu_done_nxt  = cpu_valid_i;
		cpu_tgt_nxt   = cpu_tgt_r;
		int_addr_nxt  = int_addr_r;
		chan_addr_nxt = chan_addr_r;
		io_addr_nxt   = io_addr_r;
		ob_valid_nxt  = 1'b0;
		ob_write_nxt  = ob_write_r;
		ob_fmt64_nxt  = ob_fmt64_r;
		ob_hi_nxt     = ob_hi_r;
		ob_lo_nxt     = ob_lo_r;
		if (cpu_valid_i) begin
			if (cpu_io_i) begin
				// I/O requests carry only 16 bits
				cpu_tgt_nxt  = TGT_IO;
				io_addr_nxt  = cpu_ioaddr_i;
				int_addr_nxt = {{(INT_AW-IO_AW){1'b0}}, cpu_ioaddr_i};
			end else begin
				cpu_tgt_nxt   = t;
				int_addr_nxt  = wide;
				chan_addr_nxt = wide[CHAN_AW-1:0];
			end
			if (cpu_io_i || t == TGT_PCIE) begin
				ob_valid_nxt = 1'b1;
				ob_write_nxt = cpu_write_i;
				// Short form whenever the upper dword is zero
				ob_fmt64_nxt = cpu_io_i ? 1'b0 :
				               (ob_full[PCIE_AW-1:SHORT_AW] != '0);
				ob_hi_nxt    = cpu_io_i ? '0 :
				               ob_full[PCIE_AW-1:SHORT_AW];
				ob_lo_nxt    = cpu_io_i ?
				               {{(SHORT_AW-IO_AW){1'b0}}, cpu_ioaddr_i} :
				               ob_full[SHORT_AW-1:0];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			cpu_done_r  <= 1'b0;
			cpu_tgt_r   <= TGT_NONE;
			int_addr_r  <= '0;
			chan_addr_r <= '0;
			io_addr_r   <= '0;
			ob_valid_r  <= 1'b0;
			ob_write_r  <= 1'b0;
			ob_fmt64_r  <= 1'b0;
			ob_hi_r     <= '0;
			ob_lo_r     <= '0;
		end else begin
			cpu_done_r  <= cpu_done_nxt;
			cpu_tgt_r   <= cpu_tgt_nxt;
			int_addr_r  <= int_addr_nxt;
			chan_addr_r <= chan_addr_nxt;
			io_addr_r   <= io_addr_nxt;
			ob_valid_r  <= ob_valid_nxt;
			ob_write_r  <= ob_write_nxt;
			ob_fmt64_r  <= ob_fmt64_nxt;
			ob_hi_r     <= ob_hi_nxt;
			ob_lo_r     <= ob_lo_nxt;
		end
	end

	// ****************************************************************
	// Inbound path
	// ****************************************************************
	logic               ib_done_r,  ib_done_nxt;
	target_type         ib_tgt_r,   ib_tgt_nxt;
	logic               ib_write_r, ib_write_nxt;
	logic [INT_AW-1:0]  ib_int_r,   ib_int_nxt;
	logic [CHAN_AW-1:0] ib_chan_r,  ib_chan_nxt;
	logic               ib_err_r,   ib_err_nxt;

	always_comb begin
		logic [PCIE_AW-1:0] full;
		logic               over;
		// Short headers have no upper dword to look at
		full = ib_fmt64_i ? ib_addr_i :
		       {{(PCIE_AW-SHORT_AW){1'b0}}, ib_addr_i[SHORT_AW-1:0]};
		// Bits past the internal width cannot be reached; such a
		// request is flagged and not routed to memory
		over = (full[PCIE_AW-1:INT_AW] != '0);
		ib_done_nxt  = ib_valid_i;
		ib_tgt_nxt   = ib_tgt_r;
		ib_write_nxt = ib_write_r;
		ib_int_nxt   = ib_int_r;
		ib_chan_nxt  = ib_chan_r;
		ib_err_nxt   = 1'b0;
		if (ib_valid_i) begin
			ib_write_nxt = ib_write_i;
			ib_int_nxt   = full[INT_AW-1:0];
			ib_chan_nxt  = full[CHAN_AW-1:0];
			ib_err_nxt   = over;
			ib_tgt_nxt   = over ? TGT_NONE :
			               decode_mem(full[INT_AW-1:0], ib_write_i,
			                          sect_attr_i, dram_top_i);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			ib_done_r  <= 1'b0;
			ib_tgt_r   <= TGT_NONE;
			ib_write_r <= 1'b0;
			ib_int_r   <= '0;
			ib_chan_r  <= '0;
			ib_err_r   <= 1'b0;
		end else begin
			ib_done_r  <= ib_done_nxt;
			ib_tgt_r   <= ib_tgt_nxt;
			ib_write_r <= ib_write_nxt;
			ib_int_r   <= ib_int_nxt;
			ib_chan_r  <= ib_chan_nxt;
			ib_err_r   <= ib_err_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign cpu_done_o     = cpu_done_r;
	assign cpu_tgt_o      = cpu_tgt_r;
	assign int_addr_o     = int_addr_r;
	assign chan_addr_o    = chan_addr_r;
	assign io_addr_o      = io_addr_r;
	assign ob_valid_o     = ob_valid_r;
	assign ob_write_o     = ob_write_r;
	assign ob_fmt64_o     = ob_fmt64_r;
	assign ob_addr_hi_o   = ob_hi_r;
	assign ob_addr_lo_o   = ob_lo_r;
	assign ib_done_o      = ib_done_r;
	assign ib_tgt_o       = ib_tgt_r;
	assign ib_write_o     = ib_write_r;
	assign ib_int_o       = ib_int_r;
	assign ib_chan_o      = ib_chan_r;
	assign ib_range_err_o = ib_err_r;

endmodule : addr_map_decode

// ==== pkg/addr_map_pkg.sv ====
// Constants for the system address map decoder.
// Assumes a single clock domain; all callers import the whole package.
package addr_map_pkg;

	// ****************************************************************
	// Address widths
	// ****************************************************************
	localparam int CPU_AW   = 36;
	localparam int IO_AW    = 16;
	localparam int INT_AW   = 40;
	localparam int CHAN_AW  = 36;
	localparam int PCIE_AW  = 64;
	localparam int SHORT_AW = 32;

	// ****************************************************************
	// Fixed ranges
	// ****************************************************************
	localparam logic [INT_AW-1:0] COMPAT_TOP   = 40'h00_0010_0000;
	localparam logic [INT_AW-1:0] DOS_TOP      = 40'h00_000a_0000;
	localparam logic [INT_AW-1:0] VGA_TOP      = 40'h00_000c_0000;
	localparam logic [INT_AW-1:0] SEG_F_BASE   = 40'h00_000f_0000;
	localparam logic [INT_AW-1:0] SYS_BASE     = 40'h00_fe00_0000;
	localparam logic [INT_AW-1:0] FOUR_GB      = 40'h01_0000_0000;
	localparam logic [INT_AW-1:0] INTR_BASE_DEF = 40'h00_fee0_0000;
	localparam logic [INT_AW-1:0] INTR_SIZE_DEF = 40'h00_0010_0000;

	// Sixteen kilobyte legacy sections start at 0xc0000; the last, from 0xf0000, is 64 KB
	localparam int SECT_SHIFT = 14;
	localparam logic [5:0] SECT_FIRST = 6'h30;
	localparam int N_SECT     = 13;
	localparam int SECT_IW    = 4;

	// ****************************************************************
	// Legacy section attribute codes
	// ****************************************************************
	localparam logic [1:0] ATTR_OFF = 2'h0;
	localparam logic [1:0] ATTR_RO  = 2'h1;
	localparam logic [1:0] ATTR_WO  = 2'h2;
	localparam logic [1:0] ATTR_RW  = 2'h3;
	localparam int ATTR_RD_BIT = 0;
	localparam int ATTR_WR_BIT = 1;

	// ****************************************************************
	// Routing targets
	// ****************************************************************
	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_DRAM,
		TGT_COMPAT,
		TGT_INTR,
		TGT_SYSREG,
		TGT_PCIE,
		TGT_IO
	} target_type;

endpackage : addr_map_pkg

// ==== tb/addr_map_assertions.sv ====
// Concurrent checks on the address map decoder ports.
// Assumes binding to addr_map_decode and one clock domain.
`timescale 1ns/1ns
module addr_map_assertions
	import addr_map_pkg::*;
#(
	parameter int NSECT = N_SECT
) (
	input wire logic               mclk_i,        // Clock
	input wire logic               reset_n_i,     // Sync reset
	input wire logic               cpu_valid_i,   // Request
	input wire logic               cpu_io_i,      // I/O space
	input wire logic               cpu_write_i,   // Write
	input wire logic [CPU_AW-1:0]  cpu_addr_i,    // Memory address
	input wire logic [IO_AW-1:0]   cpu_ioaddr_i,  // I/O address
	input wire logic [2*NSECT-1:0] sect_attr_i,   // Attributes
	input wire logic               ib_valid_i,    // Inbound request
	input wire logic               ib_fmt64_i,    // 64-bit header
	input wire logic [PCIE_AW-1:0] ib_addr_i,     // Inbound address
	input wire logic               cpu_done_o,    // Done
	input wire target_type         cpu_tgt_o,     // Route
	input wire logic [INT_AW-1:0]  int_addr_o,    // Internal address
	input wire logic [CHAN_AW-1:0] chan_addr_o,   // Channel address
	input wire logic [IO_AW-1:0]   io_addr_o,     // I/O address
	input wire logic               ob_valid_o,    // Outbound pulse
	input wire logic               ob_fmt64_o,    // 64-bit form
	input wire logic [31:0]        ob_addr_hi_o,  // Upper dword
	input wire logic               ib_done_o,     // Inbound done
	input wire target_type         ib_tgt_o,      // Inbound route
	input wire logic [INT_AW-1:0]  ib_int_o,      // Inbound internal
	input wire logic               ib_range_err_o // Beyond 40 bits
);
	// ****************************************************************
	// Request shapes
	// ****************************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_mem;
		cpu_valid_i && !cpu_io_i;
	endsequence
	sequence s_hi;
		s_mem ##0 cpu_addr_i[35:32] != 4'h0;
	endsequence

	AST_FMT32: assert property (
		s_mem ##0 cpu_addr_i[35:32] == 4'h0 |=> (ob_valid_o |-> !ob_fmt64_o))
		else $error("short form not used");
	AST_FMT64: assert property (
		s_hi |=> (ob_valid_o |-> ob_fmt64_o &&
		ob_addr_hi_o == {28'h0, $past(cpu_addr_i[35:32])}))
		else $error("long form wrong");
	AST_IB64: assert property (
		ib_valid_i && ib_fmt64_i && ib_addr_i[63:40] == 24'h0 |=> ib_done_o
		&& !ib_range_err_o && ib_int_o == $past(ib_addr_i[39:0]))
		else $error("inbound long form lost");
	AST_IBERR: assert property (
		ib_valid_i && ib_fmt64_i && ib_addr_i[63:40] != 24'h0 |=>
		ib_range_err_o && ib_tgt_o == TGT_NONE)
		else $error("wide inbound not flagged");
	AST_INT: assert property (
		s_mem |=> cpu_done_o && int_addr_o == {4'h0, $past(cpu_addr_i)})
		else $error("internal address wrong");
	AST_IO: assert property (
		cpu_valid_i && cpu_io_i |=> io_addr_o == $past(cpu_ioaddr_i)
		&& ob_valid_o && !ob_fmt64_o)
		else $error("io request wrong");
	AST_CHAN: assert property (
		s_mem |=> chan_addr_o == $past(cpu_addr_i))
		else $error("channel address wrong");
	AST_SECT: assert property (
		s_mem ##0 cpu_addr_i[35:14] == 22'h30 |=> cpu_tgt_o ==
		($past(sect_attr_i[cpu_write_i]) ? TGT_DRAM : TGT_COMPAT))
		else $error("section attribute ignored");
	AST_SYS: assert property (
		s_mem ##0 cpu_addr_i[35:25] == 11'h07f && cpu_addr_i[31:20] !=
		12'hfee |=> cpu_tgt_o == TGT_SYSREG)
		else $error("system region missed");
endmodule : addr_map_assertions

bind addr_map_decode addr_map_assertions #(.NSECT(NSECT)) u_chk (
	.mclk_i, .reset_n_i, .cpu_valid_i, .cpu_io_i, .cpu_write_i,
	.cpu_addr_i, .cpu_ioaddr_i, .sect_attr_i, .ib_valid_i, .ib_fmt64_i,
	.ib_addr_i, .cpu_done_o, .cpu_tgt_o, .int_addr_o, .chan_addr_o,
	.io_addr_o, .ob_valid_o, .ob_fmt64_o, .ob_addr_hi_o, .ib_done_o,
	.ib_tgt_o, .ib_int_o, .ib_range_err_o);

// ==== tb/pcie_sink_model.sv ====
// Far-side outbound link model: takes every outbound request.
// Assumes it samples the decoder's outbound pulse on the same clock.
`timescale 1ns/1ns
module pcie_sink_model (
	input  wire logic mclk_i,     // Clock
	input  wire logic reset_n_i,  // Sync reset
	input  wire logic ob_valid_i, // Outbound pulse
	input  wire logic ob_fmt64_i, // 64-bit form
	output int        n_req_o,    // Requests taken
	output int        n_wide_o    // 64-bit requests
);
	// Accepts at once; the decoder has no back-pressure to honour
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			n_req_o  <= 0;
			n_wide_o <= 0;
		end else if (ob_valid_i) begin
			n_req_o  <= n_req_o + 1;
			n_wide_o <= n_wide_o + int'(ob_fmt64_i);
		end
	end
endmodule : pcie_sink_model

// ==== tb/system_address_map_format_tb.sv ====
// Self-checking bench for the address map decoder.
// Assumes the decoder package and the outbound sink model.
`timescale 1ns/1ns
module system_address_map_format_tb;
	import addr_map_pkg::*;
	logic                mclk_i = 1'b0, reset_n_i = 1'b0;
	logic                cpu_valid_i = 1'b0, cpu_io_i = 1'b0;
	logic                cpu_write_i = 1'b0, ib_valid_i = 1'b0;
	logic                ib_fmt64_i = 1'b0, ib_write_i = 1'b0;
	logic [CPU_AW-1:0]   cpu_addr_i = '0;
	logic [IO_AW-1:0]    cpu_ioaddr_i = '0;
	logic [2*N_SECT-1:0] sect_attr_i = '0;
	logic [INT_AW-1:0]   dram_top_i = 40'h00_4000_0000;
	logic [PCIE_AW-1:0]  ib_addr_i = '0;
	logic                cpu_done_o, ob_valid_o, ob_write_o, ob_fmt64_o;
	logic                ib_done_o, ib_write_o, ib_range_err_o;
	target_type          cpu_tgt_o, ib_tgt_o;
	logic [INT_AW-1:0]   int_addr_o, ib_int_o;
	logic [CHAN_AW-1:0]  chan_addr_o, ib_chan_o;
	logic [IO_AW-1:0]    io_addr_o;
	logic [31:0]         ob_addr_hi_o, ob_addr_lo_o, seed = 32'h25;
	int                  failures = 0, compares = 0, n_ob = 0, n_wd = 0;
	int                  n_req, n_wide;

	addr_map_decode DUT (.mclk_i, .reset_n_i, .cpu_valid_i, .cpu_io_i,
		.cpu_write_i, .cpu_addr_i, .cpu_ioaddr_i, .sect_attr_i,
		.dram_top_i, .ib_valid_i, .ib_fmt64_i, .ib_write_i, .ib_addr_i,
		.cpu_done_o, .cpu_tgt_o, .int_addr_o, .chan_addr_o, .io_addr_o,
		.ob_valid_o, .ob_write_o, .ob_fmt64_o, .ob_addr_hi_o,
		.ob_addr_lo_o, .ib_done_o, .ib_tgt_o, .ib_write_o, .ib_int_o,
		.ib_chan_o, .ib_range_err_o);
	pcie_sink_model u_sink (.mclk_i, .reset_n_i, .ob_valid_i(ob_valid_o),
		.ob_fmt64_i(ob_fmt64_o), .n_req_o(n_req), .n_wide_o(n_wide));

	// ****************************************************************
	// Reference model and helpers
	// ****************************************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic target_type exp_tgt(longint a, bit wr);
		int s;
		if (a < DOS_TOP) return TGT_DRAM;
		if (a < VGA_TOP) return TGT_COMPAT;
		if (a < COMPAT_TOP) begin
			s = (a < SEG_F_BASE) ? int'((a - VGA_TOP) >> SECT_SHIFT) :
				N_SECT - 1;
			return sect_attr_i[2*s+int'(wr)] ? TGT_DRAM : TGT_COMPAT;
		end
		if (a >= INTR_BASE_DEF && a < INTR_BASE_DEF + INTR_SIZE_DEF)
			return TGT_INTR;
		if (a >= SYS_BASE && a < FOUR_GB) return TGT_SYSREG;
		return (a < dram_top_i) ? TGT_DRAM : TGT_PCIE;
	endfunction : exp_tgt
	task automatic chk(input bit ok, input string m);
		compares++;
		if (!ok) begin
			failures++;
			$display("ERROR t=%0t %s", $time, m);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic cpu_req(input bit io, input bit wr, input longint a);
		target_type et;
		bit         f;
		@(posedge mclk_i) #1;
		cpu_valid_i = 1'b1;
		cpu_io_i = io;
		cpu_write_i = wr;
		cpu_addr_i = a[CPU_AW-1:0];
		cpu_ioaddr_i = a[IO_AW-1:0];
		et = io ? TGT_IO : exp_tgt(a, wr);
		f = !io && a[35:32] != 4'h0;
		@(posedge mclk_i) #1;
		cpu_valid_i = 1'b0;
		chk(cpu_done_o === 1'b1 && cpu_tgt_o === et, "route");
		chk(int_addr_o === (io ? 40'(a[15:0]) : 40'(a)), "int");
		if (!io) chk(chan_addr_o === a[35:0], "chan");
		if (io) chk(io_addr_o === a[15:0], "io");
		chk(ob_valid_o === (io || et == TGT_PCIE), "out");
		if (io || et == TGT_PCIE) begin
			n_ob++;
			n_wd += int'(f);
			chk(ob_fmt64_o === f && ob_write_o === wr, "fmt");
			chk(ob_addr_hi_o === (f ? 32'(a >> 32) : 32'h0) &&
				ob_addr_lo_o === a[31:0], "dwords");
		end
	endtask : cpu_req
	task automatic ib_req(input bit f64, input bit wr, input longint a);
		longint e;
		bit     err;
		e = f64 ? a : (a & 64'hffff_ffff);
		err = e[63:40] != 24'h0;
		@(posedge mclk_i) #1;
		ib_valid_i = 1'b1;
		ib_fmt64_i = f64;
		ib_write_i = wr;
		ib_addr_i = a;
		@(posedge mclk_i) #1;
		ib_valid_i = 1'b0;
		chk(ib_done_o === 1'b1 && ib_range_err_o === err, "ib err");
		chk(ib_int_o === e[39:0] && ib_chan_o === e[35:0], "ib a");
		chk(ib_tgt_o === (err ? TGT_NONE : exp_tgt(e[39:0], wr)) &&
			ib_write_o === wr, "ib tgt");
	endtask : ib_req

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial forever #25 mclk_i = ~mclk_i;
	initial begin
		repeat (20000) @(posedge mclk_i);
		failures++;
		report_and_stop();
	end
	initial begin
		static longint fixed [20] = '{64'h50, 64'h9ffff, 64'ha0000, 64'hbffff,
			64'hc0000, 64'heffff, 64'hf0000, 64'hfffff, 64'h100000,
			64'h3fffffff, 64'h40000000, 64'hfdffffff, 64'hfe000000,
			64'hfedfffff, 64'hfee00000, 64'hfeefffff, 64'hfef00000,
			64'hffffffff, 64'h100000000, 64'hfffffffff};
		logic [31:0] r;
		repeat (2) @(posedge mclk_i);
		#1 reset_n_i = 1'b1;
		foreach (fixed[i]) begin
			sect_attr_i = 26'(rnd());
			cpu_req(1'b0, i[0], fixed[i]);
			cpu_req(1'b0, ~i[0], fixed[i]);
		end
		for (int c = 0; c < 4; c++) begin
			sect_attr_i = {13{2'(c)}};
			cpu_req(1'b0, 1'b0, 64'hc4000);
			cpu_req(1'b0, 1'b1, 64'hf8000);
		end
		for (int k = 0; k < 200; k++) begin
			r = rnd();
			sect_attr_i = 26'(rnd());
			case (r[1:0])
				2'h0: cpu_req(1'b0, r[2], {r[31:28], rnd()});
				2'h1: cpu_req(1'b0, r[2], r[31:12]);
				2'h2: cpu_req(1'b0, r[2], {7'h7f, r[31:7]});
				default: cpu_req(1'b1, r[2], r[31:16]);
			endcase
		end
		ib_req(1'b1, 1'b0, 64'h50);
		ib_req(1'b0, 1'b1, 64'hffffffff_000c0000);
		ib_req(1'b1, 1'b1, 64'hff_ffff_ffff);
		ib_req(1'b1, 1'b0, 64'h100_0000_0000);
		for (int k = 0; k < 60; k++) begin
			r = rnd();
			ib_req(r[0], r[1], {r[2] ? rnd() : 32'h0, rnd()});
		end
		repeat (2) @(posedge mclk_i);
		chk(n_req === n_ob && n_wide === n_wd, "sink count");
		report_and_stop();
	end
endmodule : system_address_map_format_tb
